// ### hw/sltr_pkg.sv
// Constants, codes and carrier types for the strap readback and loop tuning registers.
package sltr_pkg;

  // ****************************************************************
  // Command codes and lengths
  // ****************************************************************
  localparam logic [7:0] SLTR_CMD_STRAP_READBACK = 8'hDD;
  localparam logic [7:0] SLTR_CMD_LOOP_TUNING = 8'hDF;
  localparam logic [7:0] SLTR_PAGE_ALL = 8'hFF;
  localparam logic [2:0] SLTR_LEN_READBACK = 3'h7;
  localparam logic [2:0] SLTR_LEN_TUNING = 3'h4;

  // ****************************************************************
  // Strap pins and decode codes
  // ****************************************************************
  localparam int SLTR_NUM_STRAP = 6;
  localparam int SLTR_STRAP_LOOP = 0;
  localparam int SLTR_STRAP_CFG = 1;
  localparam int SLTR_STRAP_SYNC = 2;
  localparam int SLTR_STRAP_UNDERVOLTAGE_LOCKOUT_STRAP = 3;
  localparam int SLTR_STRAP_CH0 = 4;
  localparam int SLTR_STRAP_CH1 = 5;
  localparam logic [7:0] SLTR_CODE_RES_MAX = 8'h1E;
  localparam logic [7:0] SLTR_CODE_LOW = 8'hF1;
  localparam logic [7:0] SLTR_CODE_OPEN = 8'hF2;
  localparam logic [7:0] SLTR_CODE_HIGH = 8'hF3;
  localparam logic [7:0] SLTR_CODE_UNMEASURED = 8'hF4;
  localparam logic [7:0] SLTR_CODE_UNUSED = 8'hFF;

  // ****************************************************************
  // Loop tuning fields and defaults
  // ****************************************************************
  localparam logic SLTR_TUNE_EN_RST = 1'b1;
  localparam logic [7:0] SLTR_RESIDUAL_MAX = 8'h7F;
  localparam logic [15:0] SLTR_GAIN_BASE = 16'h0100;
  localparam logic [15:0] SLTR_GAIN_STEP = 16'h0020;
  localparam logic [7:0] SLTR_RES_BASE = 8'h0A;
  localparam logic [7:0] SLTR_RES_NOSTRAP = 8'h28;
  localparam logic [1:0] SLTR_SYNC_WAIT = 2'h3;

  typedef enum logic [1:0] {
    SLTR_SK_RES,
    SLTR_SK_LOW,
    SLTR_SK_OPEN,
    SLTR_SK_HIGH
  } sltr_kind_e;

  typedef struct packed {
    logic measured;
    sltr_kind_e kind;
    logic [4:0] index;
  } sltr_sense_s;

  typedef struct packed {
    logic [6:0] unused;
    logic enable;
    logic [7:0] residual;
    logic [15:0] gain;
  } sltr_tune_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] page;
    logic [31:0] wdata;
  } sltr_cmd_s;

endpackage

// ### hw/sltr_tune_default.sv
// Default gain and residual derived from the loop tuning strap and the supply voltages.
`timescale 1ns/100ps
module sltr_tune_default import sltr_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [7:0] i_strap_code,
  input wire logic [15:0] i_vin,
  input wire logic [15:0] i_vout,
  output logic [15:0] o_gain,
  output logic [7:0] o_residual
);

  logic [15:0] gain_nxt;
  logic [7:0] res_nxt;

  always_comb begin
    if (i_strap_code <= SLTR_CODE_RES_MAX) begin
      gain_nxt = 16'(SLTR_GAIN_BASE + 16'(i_strap_code) * SLTR_GAIN_STEP);
      res_nxt = 8'(SLTR_RES_BASE + i_strap_code);
    end else if (i_vin > i_vout) begin
      gain_nxt = 16'(SLTR_GAIN_BASE + 16'((i_vin - i_vout) >> 4));
      res_nxt = SLTR_RES_NOSTRAP;
    end else begin
      gain_nxt = SLTR_GAIN_BASE;
      res_nxt = SLTR_RES_NOSTRAP;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gain <= 16'h0000;
      o_residual <= 8'h00;
    end else if (i_ce) begin
      o_gain <= gain_nxt;
      o_residual <= res_nxt;
    end
  end

endmodule

// ### hw/sltr_regs.sv
// Strap readback and per-channel loop tuning command registers.
`timescale 1ns/100ps

// Overview of operation
// - The strap readback returns seven bytes of strap decode codes with the lowest byte fixed at FF.
// - A strap resistor in the standard series is coded 00 for the smallest up to 1E for the largest.
// - A strap tied low codes F1, open F2, tied high F3, and an unmeasured strap F4.
// - Bytes 6, 5 and 4 of the readback hold the loop tuning, configuration and sync strap codes.
// - Bytes 3, 2 and 1 hold the undervoltage lockout, channel 0 and channel 1 voltage-set codes.
// - The readback is one global read-only copy for every page, and writes to it are refused whether or not write protection is set.
// - The loop tuning register is four bytes, kept per channel by page, and readable and writable.
// - Bit 24 enables loop tuning and bits 31 to 25 always hold zero.
// - Bits 23 to 16 hold the unsigned residual from 0 to 7F.
// - Bits 15 to 0 hold the unsigned gain.
// - Gain and residual defaults come from the loop tuning strap and the voltages, enable from one.
module sltr_regs import sltr_pkg::*; #(
  parameter int NUM_CH = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire sltr_sense_s [SLTR_NUM_STRAP-1:0] i_strap_sense,
  input wire logic [15:0] i_vin,
  input wire logic [15:0] i_vout,
  input wire logic i_wr_protect,
  input wire sltr_cmd_s i_cmd,
  output logic o_ready,
  output logic o_rvalid,
  output logic [55:0] o_rdata,
  output logic [2:0] o_rlen,
  output logic o_err,
  output sltr_tune_s [NUM_CH-1:0] o_tune_cfg
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 8.");
  end

  typedef enum {
    ST_SYNC,
    ST_CAPTURE,
    ST_SETTLE,
    ST_LOAD,
    ST_RUN
  } sltr_state_e;

  sltr_state_e state_r;
  logic [1:0] wait_r;
  sltr_sense_s [SLTR_NUM_STRAP-1:0] sense_meta_r;
  sltr_sense_s [SLTR_NUM_STRAP-1:0] sense_sync_r;
  logic [55:0] readback_r;
  logic [15:0] def_gain;
  logic [7:0] def_res;
  logic run;
  logic is_read;
  logic is_write;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [7:0] decode_strap(input sltr_sense_s s);
    logic [7:0] code;
    code = SLTR_CODE_UNMEASURED;
    if (s.measured) begin
      case (s.kind)
        SLTR_SK_RES: code = (8'(s.index) > SLTR_CODE_RES_MAX) ? SLTR_CODE_RES_MAX : 8'(s.index);
        SLTR_SK_LOW: code = SLTR_CODE_LOW;
        SLTR_SK_OPEN: code = SLTR_CODE_OPEN;
        default: code = SLTR_CODE_HIGH;
      endcase
    end
    return code;
  endfunction

  function automatic sltr_tune_s clean_tune(input logic [31:0] w);
    sltr_tune_s t;
    t = sltr_tune_s'(w);
    t.unused = 7'h00;
    if (t.residual > SLTR_RESIDUAL_MAX) begin
      t.residual = SLTR_RESIDUAL_MAX;
    end
    return t;
  endfunction

  function automatic logic page_ok(input logic [7:0] page);
    return (page == SLTR_PAGE_ALL) || (page < 8'(NUM_CH));
  endfunction

  function automatic logic [55:0] tune_word(input sltr_tune_s t);
    return {24'h00_0000, t};
  endfunction

  function automatic int chan_index(input logic [7:0] page);
    return int'(page) % NUM_CH;
  endfunction

  // ****************************************************************
  // Strap synchroniser and startup sequence
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sense_meta_r <= '0;
      sense_sync_r <= '0;
    end else if (i_ce) begin
      sense_meta_r <= i_strap_sense;
      sense_sync_r <= sense_meta_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_SYNC;
      wait_r <= 2'h0;
    end else if (i_ce) begin
      case (state_r)
        ST_SYNC: begin
          wait_r <= 2'(wait_r + 2'h1);
          if (wait_r == SLTR_SYNC_WAIT) begin
            state_r <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: state_r <= ST_SETTLE;
        ST_SETTLE: state_r <= ST_LOAD;
        ST_LOAD: state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end

  assign run = (state_r == ST_RUN);
  assign is_read = run && i_cmd.valid && !i_cmd.write;
  assign is_write = run && i_cmd.valid && i_cmd.write;

  // ****************************************************************
  // Strap readback
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      readback_r <= {{SLTR_NUM_STRAP{SLTR_CODE_UNMEASURED}}, SLTR_CODE_UNUSED};
    end else if (i_ce && state_r == ST_CAPTURE) begin
      readback_r[7:0] <= SLTR_CODE_UNUSED;
      for (int i = 0; i < SLTR_NUM_STRAP; i++) begin
        readback_r[55 - 8 * i -: 8] <= decode_strap(sense_sync_r[i]);
      end
    end
  end

  sltr_tune_default u_default (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_strap_code(readback_r[55:48]),
    .i_vin(i_vin),
    .i_vout(i_vout),
    .o_gain(def_gain),
    .o_residual(def_res)
  );

  // ****************************************************************
  // Loop tuning registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tune_cfg <= '0;
    end else if (i_ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (state_r == ST_LOAD) begin
          o_tune_cfg[c] <= '{unused: 7'h00, enable: SLTR_TUNE_EN_RST,
                             residual: def_res, gain: def_gain};
        end else if (is_write && i_cmd.code == SLTR_CMD_LOOP_TUNING && !i_wr_protect &&
                     (i_cmd.page == SLTR_PAGE_ALL || i_cmd.page == 8'(c))) begin
          o_tune_cfg[c] <= clean_tune(i_cmd.wdata);
        end
      end
    end
  end

  // ****************************************************************
  // Command answers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 56'h00_0000_0000_0000;
      o_rlen <= 3'h0;
      o_err <= 1'b0;
    end else if (i_ce) begin
      o_ready <= (state_r == ST_LOAD) || run;
      o_rvalid <= 1'b0;
      o_err <= 1'b0;
      if (i_cmd.valid && !run) begin
        o_err <= 1'b1;
      end else if (is_read && i_cmd.code == SLTR_CMD_STRAP_READBACK) begin
        o_rvalid <= 1'b1;
        o_rdata <= readback_r;
        o_rlen <= SLTR_LEN_READBACK;
      end else if (is_read && i_cmd.code == SLTR_CMD_LOOP_TUNING && page_ok(i_cmd.page)) begin
        o_rvalid <= 1'b1;
        o_rlen <= SLTR_LEN_TUNING;
        if (i_cmd.page == SLTR_PAGE_ALL) begin
          o_rdata <= tune_word(o_tune_cfg[0]);
        end else begin
          o_rdata <= tune_word(o_tune_cfg[chan_index(i_cmd.page)]);
        end
      end else if (is_write && i_cmd.code == SLTR_CMD_STRAP_READBACK) begin
        o_err <= 1'b1;
      end else if (is_write && i_cmd.code == SLTR_CMD_LOOP_TUNING && page_ok(i_cmd.page) &&
                   !i_wr_protect) begin
        o_err <= 1'b0;
      end else if (i_cmd.valid) begin
        o_err <= 1'b1;
      end
    end
  end

endmodule

// ### bench/sltr_regs_assertions.sv
// Concurrent checks on the strap readback and loop tuning command port.
`timescale 1ns/100ps
module sltr_regs_assertions import sltr_pkg::*; #(
  parameter int NUM_CH = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_wr_protect,
  input wire sltr_cmd_s i_cmd,
  input wire logic o_ready,
  input wire logic o_rvalid,
  input wire logic [55:0] o_rdata,
  input wire logic [2:0] o_rlen,
  input wire logic o_err,
  input wire sltr_tune_s [NUM_CH-1:0] o_tune_cfg
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic rd;
  logic wr;
  logic df1;
  assign rd = i_cmd.valid && i_ce && o_ready && !i_cmd.write;
  assign wr = i_cmd.valid && i_ce && o_ready && i_cmd.write;
  assign df1 = i_cmd.code == SLTR_CMD_LOOP_TUNING && i_cmd.page == 8'h01;
  AST_RB_READ: assert property (rd && i_cmd.code == SLTR_CMD_STRAP_READBACK
    |=> o_rvalid && o_rlen == SLTR_LEN_READBACK && o_rdata[7:0] == 8'hFF)
    else $error("readback answer wrong");
  AST_RB_WRITE: assert property (wr && i_cmd.code == SLTR_CMD_STRAP_READBACK
    |=> o_err && $stable(o_tune_cfg)) else $error("readback write not refused");
  AST_TUNE_READ: assert property (rd && df1 |=> o_rvalid && o_rlen == SLTR_LEN_TUNING
    && o_rdata == {24'h0, $past(o_tune_cfg[1])}) else $error("tuning read wrong");
  AST_TUNE_WRITE: assert property (wr && df1 && !i_wr_protect
    && i_cmd.wdata[23:16] <= SLTR_RESIDUAL_MAX
    |=> !o_err && o_tune_cfg[1] == {7'h0, $past(i_cmd.wdata[24:0])})
    else $error("tuning write wrong");
  AST_RES_SAT: assert property (wr && df1 && !i_wr_protect
    && i_cmd.wdata[23:16] > SLTR_RESIDUAL_MAX |=> o_tune_cfg[1].residual == SLTR_RESIDUAL_MAX)
    else $error("residual not saturated");
  AST_WP: assert property (wr && i_cmd.code == SLTR_CMD_LOOP_TUNING && i_wr_protect
    |=> o_err && $stable(o_tune_cfg)) else $error("protected write taken");
  AST_UNUSED: assert property (o_tune_cfg[0].unused == 7'h0
    && o_tune_cfg[1].unused == 7'h0) else $error("unused bits set");
  AST_IDLE: assert property (!i_cmd.valid |=> !o_rvalid && !o_err)
    else $error("answer without request");
  cover property (rd && i_cmd.code == SLTR_CMD_STRAP_READBACK);
  cover property (wr && df1);
  cover property (o_err);
endmodule

bind sltr_regs sltr_regs_assertions #(.NUM_CH(NUM_CH)) sltr_regs_assertions_i (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_wr_protect(i_wr_protect),
  .i_cmd(i_cmd), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
  .o_rlen(o_rlen), .o_err(o_err), .o_tune_cfg(o_tune_cfg));

// ### bench/sltr_host_model.sv
// Host controller model that issues one register command at a time.
`timescale 1ns/100ps
module sltr_host_model import sltr_pkg::*; (
  input wire logic i_mclk,
  output sltr_cmd_s o_cmd
);
  initial o_cmd = '0;
  // Each call drives one request, then releases it with inverted fields.
  task automatic send(input logic w, input logic [7:0] c, input logic [7:0] p,
                      input logic [31:0] d);
    @(negedge i_mclk);
    o_cmd <= {1'b1, w, c, p, d};
    @(negedge i_mclk);
    o_cmd <= {1'b0, ~w, ~c, ~p, ~d};
  endtask
endmodule

// ### bench/tb.sv
// Self-checking testbench for the strap readback and loop tuning registers.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb import sltr_pkg::*;;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr_protect = 1'b0;
  logic i_ce = 1'b1;
  sltr_cmd_s i_cmd;
  logic o_ready;
  logic o_rvalid;
  logic o_err;
  logic [55:0] o_rdata;
  logic [2:0] o_rlen;
  sltr_tune_s [1:0] o_tune_cfg;
  sltr_sense_s [SLTR_NUM_STRAP-1:0] sense = {1'b1, SLTR_SK_RES, 5'h1F, 1'b0, SLTR_SK_RES, 5'h00,
    1'b1, SLTR_SK_HIGH, 5'h00, 1'b1, SLTR_SK_OPEN, 5'h00,
    1'b1, SLTR_SK_LOW, 5'h00, 1'b1, SLTR_SK_RES, 5'h05};
  int err_count = 0;
  int tests_run = 0;
  localparam logic [55:0] EXP_RB = 56'h05_F1F2_F3F4_1EFF;
  localparam logic [31:0] EXP_DEF = 32'h010F_01A0;
  always #5 i_mclk = ~i_mclk;
  sltr_regs #(.NUM_CH(2)) sltr_regs_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_strap_sense(sense), .i_vin(16'h0C00), .i_vout(16'h0100),
    .i_wr_protect(i_wr_protect), .i_cmd(i_cmd), .o_ready(o_ready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_rlen(o_rlen), .o_err(o_err), .o_tune_cfg(o_tune_cfg));
  sltr_host_model sltr_host_model_i (.i_mclk(i_mclk), .o_cmd(i_cmd));

  task automatic send(input logic w, input logic [7:0] c, input logic [7:0] p,
                      input logic [31:0] d);
    sltr_host_model_i.send(w, c, p, d);
  endtask

  task automatic t_start();
    repeat (12) @(negedge i_mclk);
    i_rst_b = 1'b1;
    send(1'b0, SLTR_CMD_STRAP_READBACK, 8'h00, 32'h0);
    `CHK(o_err, 1'b1)
    for (int k = 0; k < 20 && o_ready !== 1'b1; k++) @(negedge i_mclk);
    `CHK(o_ready, 1'b1)
    `CHK(o_tune_cfg[0], EXP_DEF)
    `CHK(o_tune_cfg[1], EXP_DEF)
    $display("Test start done");
  endtask

  task automatic t_readback();
    send(1'b0, SLTR_CMD_STRAP_READBACK, 8'h00, 32'h0);
    `CHK(o_rvalid, 1'b1)
    `CHK(o_rlen, 3'h7)
    `CHK(o_rdata, EXP_RB)
    `CHK(o_rdata[47:24], 24'hF1_F2F3)
    `CHK(o_rdata[55:32], 24'h05_F1F2)
    `CHK(o_rdata[31:8], 24'hF3_F41E)
    send(1'b0, SLTR_CMD_STRAP_READBACK, 8'h01, 32'h0);
    `CHK({o_rvalid, o_rdata}, {1'b1, EXP_RB})
    send(1'b1, SLTR_CMD_STRAP_READBACK, 8'h00, 32'h1234_5678);
    `CHK(o_err, 1'b1)
    send(1'b0, SLTR_CMD_STRAP_READBACK, 8'h00, 32'h0);
    `CHK({o_rvalid, o_rdata}, {1'b1, EXP_RB})
    send(1'b0, 8'hDE, 8'h00, 32'h0);
    `CHK({o_rvalid, o_err}, 2'b01)
    $display("Test readback done");
  endtask

  task automatic t_tuning();
    send(1'b1, SLTR_CMD_LOOP_TUNING, 8'h01, 32'hFF23_0190);
    `CHK(o_err, 1'b0)
    `CHK(o_tune_cfg[1], 32'h0123_0190)
    `CHK(o_tune_cfg[0], EXP_DEF)
    send(1'b0, SLTR_CMD_LOOP_TUNING, 8'h01, 32'h0);
    `CHK({o_rvalid, o_rlen, o_rdata}, {1'b1, 3'h4, 56'h0123_0190})
    send(1'b1, SLTR_CMD_LOOP_TUNING, 8'h01, 32'h0090_0ABC);
    `CHK(o_tune_cfg[1], 32'h007F_0ABC)
    i_wr_protect = 1'b1;
    send(1'b1, SLTR_CMD_LOOP_TUNING, 8'h01, 32'h0100_0200);
    `CHK({o_err, o_tune_cfg[1]}, {1'b1, 32'h007F_0ABC})
    i_wr_protect = 1'b0;
    send(1'b1, SLTR_CMD_LOOP_TUNING, 8'h02, 32'h0100_0200);
    `CHK(o_err, 1'b1)
    send(1'b1, SLTR_CMD_LOOP_TUNING, SLTR_PAGE_ALL, 32'h0100_FFFF);
    `CHK(o_tune_cfg, {32'h0100_FFFF, 32'h0100_FFFF})
    send(1'b0, SLTR_CMD_LOOP_TUNING, SLTR_PAGE_ALL, 32'h0);
    `CHK({o_rvalid, o_rlen, o_rdata}, {1'b1, 3'h4, 56'h0100_FFFF})
    $display("Test tuning done");
  endtask

  task automatic t_hold();
    @(negedge i_mclk);
    i_ce = 1'b0;
    send(1'b1, SLTR_CMD_LOOP_TUNING, 8'h00, 32'h0100_0300);
    `CHK({o_err, o_tune_cfg[0]}, {1'b0, 32'h0100_FFFF})
    i_ce = 1'b1;
    $display("Test hold done");
  endtask

  task automatic t_reset();
    @(negedge i_mclk);
    i_rst_b = 1'b0;
    sense[0] = '{1'b1, SLTR_SK_OPEN, 5'h00};
    repeat (2) @(negedge i_mclk);
    `CHK({o_ready, o_tune_cfg}, 65'h0)
    i_rst_b = 1'b1;
    for (int k = 0; k < 20 && o_ready !== 1'b1; k++) @(negedge i_mclk);
    `CHK(o_ready, 1'b1)
    `CHK(o_tune_cfg, {2{32'h0128_01B0}})
    send(1'b0, SLTR_CMD_STRAP_READBACK, 8'h00, 32'h0);
    `CHK(o_rdata[55:48], SLTR_CODE_OPEN)
    `CHK(o_rdata, 56'hF2_F1F2_F3F4_1EFF)
    $display("Test reset done");
  endtask

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d errors", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    t_start();
    t_readback();
    t_tuning();
    t_hold();
    t_reset();
    end_of_test();
  end

  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule
